// file: rtl/isp_input_sync_param.sv
// Input sync parameter object: entry storage, sync selection, timing capture and error tracking.
//
// Behaviour
// - Mode 0 runs free; mode 34 samples on the output buffer channel event.
// - Mode 1 samples on the input buffer channel event, for no-output setups.
// - Modes 2 and 3 sample on the first or second sync pulse.
// - In distributed clock mode report ns from first sync pulse to sampling.
// - In distributed clock mode report ns from sampling until data available.
// - In distributed clock mode report maximum ns from second pulse to sampling.
// - Supported modes: bit 0 free run, bit 1 buffer event, bits 2-3 01 clock.
// - Bits 4-5 read 01 with outputs present, 10 without outputs.
// - Bit 14 set: dynamic times, captured when subindex 08 is written.
// - A reserved 32-bit read-write code word with no effect.
// - A 32-bit read-write password guarding calibration data against change.
// - In loader state accept firmware words without any hardware suitability check.
// - Cycle time in ns: local timer, master cycle or sync pulse period.
// - Count missed buffer events in state_a, distributed clock mode only.
// - Count cycles not completed in time or started too early.
// - Flag sync error when last cycle's data came late, clock mode only.
`timescale 1ns/10ps
`default_nettype none
module isp_input_sync_param #(
	parameter logic        HAS_OUTPUTS  = 1'b1,
	parameter logic        DC_SUPPORTED = 1'b1,
	parameter logic [31:0] CALIB_KEY    = 32'h0000_0000
) (
	// Clock and reset.
	input  wire logic                 clk_sys,
	input  wire logic                 rst_b,
	// Object dictionary access from the mailbox.
	input  wire isp_pkg::isp_req_type odReq,
	output var  isp_pkg::isp_rsp_type odRsp_q,
	// Sync events, each a one-cycle pulse.
	input  wire logic                 firstSyncPulse,
	input  wire logic                 secondSyncPulse,
	input  wire logic                 inputBufferEvent,
	input  wire logic                 outputBufferEvent,
	// Sampler handshake.
	input  wire logic                 sampleDone,
	output var  logic                 sampleStrobe_q,
	// Device state.
	input  wire logic                 stateA,
	input  wire logic                 firmwareLoaderState,
	// Firmware download words.
	input  wire logic                 fwWordValid,
	input  wire logic [31:0]          fwWord,
	output var  logic                 fwStoreValid_q,
	output var  logic [31:0]          fwStoreWord_q,
	// Status.
	output var  logic                 calibWriteAllow_q,
	output var  logic                 syncError_q
);
	// Entry storage.
	logic [15:0] mode_q;
	logic [31:0] cycleNs_q;
	logic [31:0] codeWord_q;
	logic [31:0] password_q;
	logic [31:0] shiftNs_q;
	logic [31:0] copyNs_q;
	logic [31:0] minDelayNs_q;
	logic [31:0] maxDelayNs_q;
	logic [31:0] liveShift_q;
	logic [31:0] liveCopy_q;
	logic [31:0] liveMinDelay_q;
	logic [31:0] liveMaxDelay_q;
	logic        sampleBusy_q;
	logic        freshSample_q;
	logic [15:0] errCount [isp_pkg::ERR_COUNTERS];
	logic [isp_pkg::ERR_COUNTERS-1:0] errBump;

	// Mode decode.
	wire logic modeFree   = (mode_q == isp_pkg::MODE_FREE_RUN);
	wire logic modeOutBuf = (mode_q == isp_pkg::MODE_OUT_BUFFER);
	wire logic modeInBuf  = (mode_q == isp_pkg::MODE_IN_BUFFER);
	wire logic modeFirst  = (mode_q == isp_pkg::MODE_DC_FIRST);
	wire logic modeSecond = (mode_q == isp_pkg::MODE_DC_SECOND);
	wire logic dcMode     = modeFirst || modeSecond;

	// Elapsed-time sources.
	logic [31:0] sinceFree;
	logic [31:0] sinceFirst;
	logic [31:0] sinceSecond;
	logic [31:0] sinceSample;
	logic [31:0] sinceCycle;

	// The free-run period follows the cycle time entry, so rewriting it retimes the next tick.
	wire logic freeTick   = modeFree && (sinceFree >= (cycleNs_q - isp_pkg::CLK_STEP_NS));
	wire logic cycleEvent = freeTick
		|| (modeOutBuf && outputBufferEvent)
		|| (modeInBuf && inputBufferEvent)
		|| (modeFirst && firstSyncPulse)
		|| (modeSecond && secondSyncPulse);

	isp_ns_timer u_free_timer (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.restart   (freeTick || !modeFree),
		.elapsed_q (sinceFree)
	);

	isp_ns_timer u_first_timer (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.restart   (firstSyncPulse),
		.elapsed_q (sinceFirst)
	);

	isp_ns_timer u_second_timer (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.restart   (secondSyncPulse),
		.elapsed_q (sinceSecond)
	);

	isp_ns_timer u_sample_timer (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.restart   (cycleEvent),
		.elapsed_q (sinceSample)
	);

	isp_ns_timer u_cycle_timer (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.restart   (cycleEvent),
		.elapsed_q (sinceCycle)
	);

	// Supported modes, fixed by the build.
	logic [15:0] supported;
	always_comb begin
		supported = isp_pkg::RST_ZERO16;
		supported[isp_pkg::SUP_FREE_BIT] = 1'b1;
		supported[isp_pkg::SUP_BUFFER_BIT] = 1'b1;
		if (DC_SUPPORTED) begin
			supported[isp_pkg::SUP_DC_LSB +: 2] = isp_pkg::SUP_DC_YES;
			supported[isp_pkg::SUP_SHIFT_LSB +: 2] = HAS_OUTPUTS ? isp_pkg::SHIFT_LOCAL
				: isp_pkg::SHIFT_SECOND;
			supported[isp_pkg::SUP_DYNAMIC_BIT] = 1'b1;
		end
	end

	// Request decode.
	wire logic hitSync   = odReq.valid && (odReq.index == isp_pkg::IDX_INPUT_SYNC);
	wire logic hitCode   = odReq.valid && (odReq.index == isp_pkg::IDX_CODE_WORD)
		&& (odReq.sub == isp_pkg::SUB_COUNT);
	wire logic hitPass   = odReq.valid && (odReq.index == isp_pkg::IDX_CALIB_PASS)
		&& (odReq.sub == isp_pkg::SUB_COUNT);
	wire logic modeLegal = ((odReq.data[15:0] == isp_pkg::MODE_FREE_RUN)
		|| (odReq.data[15:0] == isp_pkg::MODE_IN_BUFFER)
		|| (odReq.data[15:0] == isp_pkg::MODE_OUT_BUFFER)
		|| (DC_SUPPORTED && ((odReq.data[15:0] == isp_pkg::MODE_DC_FIRST)
			|| (odReq.data[15:0] == isp_pkg::MODE_DC_SECOND))))
		&& (odReq.data[31:16] == isp_pkg::RST_ZERO16);
	wire logic wrMode    = hitSync && odReq.write && (odReq.sub == isp_pkg::SUB_MODE) && modeLegal;
	wire logic wrCycle   = hitSync && odReq.write && (odReq.sub == isp_pkg::SUB_CYCLE);
	wire logic wrMeasure = hitSync && odReq.write && (odReq.sub == isp_pkg::SUB_MEASURE)
		&& DC_SUPPORTED;
	wire logic wrCode    = hitCode && odReq.write;
	wire logic wrPass    = hitPass && odReq.write;
	wire logic wrAny     = wrMode || wrCycle || wrMeasure || wrCode || wrPass;

	// Read selection.
	logic [31:0] syncRead;
	logic        syncReadOk;
	always_comb begin
		syncRead = isp_pkg::RST_ZERO32;
		syncReadOk = 1'b1;
		unique case (odReq.sub)
			isp_pkg::SUB_COUNT:       syncRead = {24'h000000, isp_pkg::RST_COUNT};
			isp_pkg::SUB_MODE:        syncRead = {16'h0000, mode_q};
			isp_pkg::SUB_CYCLE:       syncRead = cycleNs_q;
			isp_pkg::SUB_SHIFT:       syncRead = shiftNs_q;
			isp_pkg::SUB_SUPPORTED:   syncRead = {16'h0000, supported};
			isp_pkg::SUB_MIN_CYCLE:   syncRead = isp_pkg::RST_MIN_CYCLE;
			isp_pkg::SUB_COPY:        syncRead = copyNs_q;
			isp_pkg::SUB_MIN_DELAY:   syncRead = minDelayNs_q;
			isp_pkg::SUB_MAX_DELAY:   syncRead = maxDelayNs_q;
			isp_pkg::SUB_MISSED:      syncRead = {16'h0000, errCount[isp_pkg::ERR_MISSED]};
			isp_pkg::SUB_OVERRUN:     syncRead = {16'h0000, errCount[isp_pkg::ERR_OVERRUN]};
			isp_pkg::SUB_SHORT_SHIFT: syncRead = {16'h0000, errCount[isp_pkg::ERR_SHORT]};
			isp_pkg::SUB_SYNC_ERROR:  syncRead = {31'h00000000, syncError_q};
			default:                  syncReadOk = 1'b0;
		endcase
	end

	wire logic reqOk = (hitSync && (odReq.write ? wrAny : syncReadOk)) || hitCode || hitPass;
	// Write answers carry zero data, so a write never echoes the stored password.
	wire logic [31:0] readData = (hitCode && !odReq.write) ? codeWord_q
		: (hitPass && !odReq.write) ? password_q
		: (hitSync && !odReq.write) ? syncRead
		: isp_pkg::RST_ZERO32;

	// Response register, one cycle after each request.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			odRsp_q <= '0;
		end else begin
			odRsp_q.valid <= odReq.valid;
			odRsp_q.abort <= odReq.valid && !reqOk;
			odRsp_q.data <= readData;
		end
	end

	// Writable entries.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			mode_q <= isp_pkg::RST_MODE;
			cycleNs_q <= isp_pkg::RST_CYCLE_NS;
			codeWord_q <= isp_pkg::RST_ZERO32;
			password_q <= isp_pkg::RST_ZERO32;
		end else begin
			if (wrMode) begin
				mode_q <= odReq.data[15:0];
			end
			if (wrCycle) begin
				cycleNs_q <= odReq.data;
			end
			if (wrCode) begin
				codeWord_q <= odReq.data;
			end
			if (wrPass) begin
				password_q <= odReq.data;
			end
		end
	end

	// Calibration data may only change while the password holds the unlock key.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			calibWriteAllow_q <= 1'b0;
		end else begin
			calibWriteAllow_q <= (password_q == CALIB_KEY);
		end
	end

	// Sampling handshake; a new strobe wins over a completion in the same cycle.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sampleStrobe_q <= 1'b0;
			sampleBusy_q <= 1'b0;
			freshSample_q <= 1'b0;
		end else begin
			sampleStrobe_q <= cycleEvent;
			sampleBusy_q <= cycleEvent || (sampleBusy_q && !sampleDone);
			freshSample_q <= (sampleDone && sampleBusy_q) || (freshSample_q && !inputBufferEvent);
		end
	end

	// Live timing capture in distributed clock mode.
	wire logic dcSample = dcMode && cycleEvent;
	wire logic dcDone   = dcMode && sampleDone && sampleBusy_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			liveShift_q <= isp_pkg::RST_ZERO32;
			liveCopy_q <= isp_pkg::RST_ZERO32;
			liveMinDelay_q <= isp_pkg::NS_MAX;
			liveMaxDelay_q <= isp_pkg::RST_ZERO32;
		end else if (wrMeasure) begin
			liveMinDelay_q <= isp_pkg::NS_MAX;
			liveMaxDelay_q <= isp_pkg::RST_ZERO32;
		end else begin
			if (dcSample) begin
				liveShift_q <= modeFirst ? isp_pkg::RST_ZERO32 : sinceFirst;
				if (sinceSecond > liveMaxDelay_q) begin
					liveMaxDelay_q <= modeSecond ? isp_pkg::RST_ZERO32 : sinceSecond;
				end
				if (sinceSecond < liveMinDelay_q) begin
					liveMinDelay_q <= modeSecond ? isp_pkg::RST_ZERO32 : sinceSecond;
				end
			end
			if (dcDone) begin
				liveCopy_q <= sinceSample;
			end
		end
	end

	// Reported times change only when the master asks for a measurement.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			shiftNs_q <= isp_pkg::RST_ZERO32;
			copyNs_q <= isp_pkg::RST_ZERO32;
			minDelayNs_q <= isp_pkg::RST_ZERO32;
			maxDelayNs_q <= isp_pkg::RST_ZERO32;
		end else if (wrMeasure) begin
			shiftNs_q <= liveShift_q;
			copyNs_q <= liveCopy_q;
			minDelayNs_q <= (liveMinDelay_q == isp_pkg::NS_MAX) ? isp_pkg::RST_ZERO32
				: liveMinDelay_q;
			maxDelayNs_q <= liveMaxDelay_q;
		end
	end

	// Error detection.
	assign errBump[isp_pkg::ERR_MISSED] = dcMode && stateA && inputBufferEvent
		&& !freshSample_q;
	assign errBump[isp_pkg::ERR_OVERRUN] = stateA && cycleEvent
		&& (sampleBusy_q || (sinceCycle < isp_pkg::RST_MIN_CYCLE));
	assign errBump[isp_pkg::ERR_SHORT] = dcMode && stateA && secondSyncPulse
		&& (sinceFirst < liveCopy_q);

	generate
		for (genvar i = 0; i < isp_pkg::ERR_COUNTERS; i++) begin : g_err
			isp_sat_counter #(
				.WIDTH (16)
			) u_count (
				.clk_sys (clk_sys),
				.rst_b   (rst_b),
				.bump    (errBump[i]),
				.count_q (errCount[i])
			);
		end
	endgenerate

	// The flag describes only the last cycle, so each cycle boundary rewrites it.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			syncError_q <= 1'b0;
		end else if (!dcMode) begin
			syncError_q <= 1'b0;
		end else if (cycleEvent) begin
			syncError_q <= sampleBusy_q;
		end
	end

	// Image words pass straight to storage; suitability is the master's job.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			fwStoreValid_q <= 1'b0;
			fwStoreWord_q <= isp_pkg::RST_ZERO32;
		end else begin
			fwStoreValid_q <= firmwareLoaderState && fwWordValid;
			fwStoreWord_q <= fwWord;
		end
	end
endmodule
`default_nettype wire

// file: rtl/isp_pkg.sv
// Constants, entry addresses and carrier types of the input sync parameter object.
package isp_pkg;
	localparam int          CLK_PERIOD_NS   = 5;
	localparam logic [31:0] CLK_STEP_NS     = 32'h0000_0005;
	localparam logic [31:0] NS_MAX          = 32'hffff_ffff;

	// Object dictionary indices and subindices.
	localparam logic [15:0] IDX_INPUT_SYNC  = 16'h1c33;
	localparam logic [15:0] IDX_CODE_WORD   = 16'hf008;
	localparam logic [15:0] IDX_CALIB_PASS  = 16'hf009;
	localparam logic [7:0]  SUB_COUNT       = 8'h00;
	localparam logic [7:0]  SUB_MODE        = 8'h01;
	localparam logic [7:0]  SUB_CYCLE       = 8'h02;
	localparam logic [7:0]  SUB_SHIFT       = 8'h03;
	localparam logic [7:0]  SUB_SUPPORTED   = 8'h04;
	localparam logic [7:0]  SUB_MIN_CYCLE   = 8'h05;
	localparam logic [7:0]  SUB_COPY        = 8'h06;
	localparam logic [7:0]  SUB_MIN_DELAY   = 8'h07;
	localparam logic [7:0]  SUB_MEASURE     = 8'h08;
	localparam logic [7:0]  SUB_MAX_DELAY   = 8'h09;
	localparam logic [7:0]  SUB_MISSED      = 8'h0b;
	localparam logic [7:0]  SUB_OVERRUN     = 8'h0c;
	localparam logic [7:0]  SUB_SHORT_SHIFT = 8'h0d;
	localparam logic [7:0]  SUB_SYNC_ERROR  = 8'h20;

	// Reset values.
	localparam logic [7:0]  RST_COUNT       = 8'h20;
	localparam logic [15:0] RST_MODE        = 16'h0000;
	localparam logic [31:0] RST_CYCLE_NS    = 32'h000f_4240;
	localparam logic [31:0] RST_MIN_CYCLE   = 32'h0001_86a0;
	localparam logic [31:0] RST_ZERO32      = 32'h0000_0000;
	localparam logic [15:0] RST_ZERO16      = 16'h0000;

	// Sync mode codes.
	localparam logic [15:0] MODE_FREE_RUN   = 16'h0000;
	localparam logic [15:0] MODE_IN_BUFFER  = 16'h0001;
	localparam logic [15:0] MODE_DC_FIRST   = 16'h0002;
	localparam logic [15:0] MODE_DC_SECOND  = 16'h0003;
	localparam logic [15:0] MODE_OUT_BUFFER = 16'h0022;

	// Supported-modes field layout.
	localparam int          SUP_FREE_BIT    = 0;
	localparam int          SUP_BUFFER_BIT  = 1;
	localparam int          SUP_DC_LSB      = 2;
	localparam int          SUP_SHIFT_LSB   = 4;
	localparam int          SUP_DYNAMIC_BIT = 14;
	localparam logic [1:0]  SUP_DC_YES      = 2'h1;
	localparam logic [1:0]  SHIFT_LOCAL     = 2'h1;
	localparam logic [1:0]  SHIFT_SECOND    = 2'h2;

	// Number of saturating error counters.
	localparam int          ERR_COUNTERS    = 3;
	localparam int          ERR_MISSED      = 0;
	localparam int          ERR_OVERRUN     = 1;
	localparam int          ERR_SHORT       = 2;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] data;
	} isp_req_type;

	typedef struct packed {
		logic        valid;
		logic        abort;
		logic [31:0] data;
	} isp_rsp_type;
endpackage

// file: rtl/isp_sat_counter.sv
// Saturating event counter that clears only on reset.
`timescale 1ns/10ps
`default_nettype none
module isp_sat_counter #(
	parameter int WIDTH = 16
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	// Event and count.
	input  wire logic             bump,
	output var  logic [WIDTH-1:0] count_q
);
	wire logic [WIDTH-1:0] countMax = {WIDTH{1'b1}};
	wire logic             atMax    = (count_q == countMax);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			count_q <= '0;
		end else if (bump && !atMax) begin
			count_q <= count_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: rtl/isp_ns_timer.sv
// Elapsed-time counter in nanoseconds, restarted by a pulse and saturating at the top.
`timescale 1ns/10ps
`default_nettype none
module isp_ns_timer (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Control and time.
	input  wire logic        restart,
	output var  logic [31:0] elapsed_q
);
	// Counting in nanoseconds avoids a divider when comparing against entries held in ns.
	wire logic        nearTop = (elapsed_q > (isp_pkg::NS_MAX - isp_pkg::CLK_STEP_NS));
	wire logic [31:0] stepped = nearTop ? isp_pkg::NS_MAX : (elapsed_q + isp_pkg::CLK_STEP_NS);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			elapsed_q <= isp_pkg::RST_ZERO32;
		end else if (restart) begin
			elapsed_q <= isp_pkg::RST_ZERO32;
		end else begin
			elapsed_q <= stepped;
		end
	end
endmodule
`default_nettype wire

// file: verif/isp_param_monitor.sv
// Assertion checker bound to the input sync parameter object.
`timescale 1ns/10ps
`default_nettype none
module isp_param_monitor (
	// Clock and reset.
	input wire logic                 clk_sys,
	input wire logic                 rst_b,
	// Object access.
	input wire isp_pkg::isp_req_type odReq,
	input wire isp_pkg::isp_rsp_type odRsp_q,
	// Events and sampling.
	input wire logic                 firstSyncPulse,
	input wire logic                 secondSyncPulse,
	input wire logic                 inputBufferEvent,
	input wire logic                 outputBufferEvent,
	input wire logic                 sampleStrobe_q,
	input wire logic                 syncError_q,
	// Firmware words.
	input wire logic                 firmwareLoaderState,
	input wire logic                 fwWordValid,
	input wire logic                 fwStoreValid_q
);
	isp_pkg::isp_req_type lastReq_q;
	logic [15:0]          mode_q;
	wire logic            modeWrite = odRsp_q.valid && !odRsp_q.abort && lastReq_q.write
		&& lastReq_q.index == 16'h1c33 && lastReq_q.sub == 8'h01;
	wire logic            dcMode = mode_q == 16'h2 || mode_q == 16'h3;
	// This copy of the mode lags the design by one cycle, so answer cycles are skipped.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			lastReq_q <= '0;
			mode_q <= 16'h0;
		end else begin
			lastReq_q <= odReq;
			if (modeWrite) begin
				mode_q <= lastReq_q.data[15:0];
			end
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	chk_answer_next: assert property (odReq.valid |=> odRsp_q.valid
		&& (!$past(odReq.write) || odRsp_q.data == 32'h0)) else $error("bad answer");
	chk_out_buffer: assert property (mode_q == 16'h22 && outputBufferEvent
		&& !odRsp_q.valid |=> sampleStrobe_q) else $error("no strobe on output event");
	chk_in_buffer: assert property (mode_q == 16'h1 && inputBufferEvent
		&& !odRsp_q.valid |=> sampleStrobe_q) else $error("no strobe on input event");
	chk_first_pulse: assert property (mode_q == 16'h2 && firstSyncPulse
		&& !odRsp_q.valid |=> sampleStrobe_q) else $error("no strobe on first pulse");
	chk_second_pulse: assert property (mode_q == 16'h3 && secondSyncPulse
		&& !odRsp_q.valid |=> sampleStrobe_q) else $error("no strobe on second pulse");
	chk_strobe_cause: assert property (sampleStrobe_q && mode_q == 16'h2
		&& !$past(odRsp_q.valid) |-> $past(firstSyncPulse)) else $error("stray strobe");
	chk_fw_pass: assert property ($past(rst_b) |-> fwStoreValid_q ==
		($past(firmwareLoaderState) && $past(fwWordValid))) else $error("bad store pulse");
	chk_sync_quiet: assert property ($past(rst_b) && !dcMode && !$past(dcMode)
		&& !odRsp_q.valid && !$past(odRsp_q.valid) |-> !syncError_q) else $error("sync error");
	cov_first_strobe: cover property (mode_q == 16'h2 && firstSyncPulse ##1 sampleStrobe_q);
	cov_refused: cover property (odRsp_q.valid && odRsp_q.abort);
	cov_fw_store: cover property (fwStoreValid_q);
endmodule
bind isp_input_sync_param isp_param_monitor i_mon (.clk_sys(clk_sys), .rst_b(rst_b),
	.odReq(odReq), .odRsp_q(odRsp_q), .firstSyncPulse(firstSyncPulse),
	.secondSyncPulse(secondSyncPulse), .inputBufferEvent(inputBufferEvent),
	.outputBufferEvent(outputBufferEvent), .sampleStrobe_q(sampleStrobe_q),
	.syncError_q(syncError_q), .firmwareLoaderState(firmwareLoaderState),
	.fwWordValid(fwWordValid), .fwStoreValid_q(fwStoreValid_q));
`default_nettype wire

// file: verif/isp_master_model.sv
// Behavioural fieldbus master issuing object accesses and firmware words.
`timescale 1ns/10ps
`default_nettype none
module isp_master_model #(
	parameter logic [7:0] HW_VERSION = 8'h3c
) (
	// Clock and answers.
	input  wire logic                 clk_sys,
	input  wire isp_pkg::isp_rsp_type odRsp_q,
	// Requests and firmware words.
	output var  isp_pkg::isp_req_type odReq,
	output var  logic                 fwWordValid,
	output var  logic [31:0]          fwWord
);
	// The hardware version value is arbitrary.
	initial begin
		odReq = '0;
		fwWordValid = 1'b0;
		fwWord = 32'h0;
	end
	task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] subIdx,
			input logic [31:0] d, output isp_pkg::isp_rsp_type rsp);
		@(negedge clk_sys);
		odReq = '{valid: 1'b1, write: w, index: idx, sub: subIdx, data: d};
		@(negedge clk_sys);
		rsp = odRsp_q;
		// Released data is inverted so a stale word never looks live.
		odReq.valid = 1'b0;
		odReq.data = ~d;
	endtask
	task automatic load_fw(input logic [31:0] word, input logic [7:0] imgHw);
		if (imgHw === HW_VERSION) begin
			@(negedge clk_sys);
			fwWord = word;
			fwWordValid = 1'b1;
			@(negedge clk_sys);
			fwWordValid = 1'b0;
			fwWord = ~word;
		end
	endtask
endmodule
`default_nettype wire

// file: verif/isp_input_sync_param_test.sv
// Self-checking bench for the input sync parameter object.
`timescale 1ns/10ps
`default_nettype none
module isp_input_sync_param_test;
	isp_pkg::isp_req_type odReq;
	isp_pkg::isp_rsp_type odRsp_q;
	logic                 clk_sys = 1'b0;
	logic                 rst_b = 1'b0;
	logic                 stateA = 1'b0;
	logic                 loader = 1'b0;
	logic [4:0]           evt = 5'h0;
	logic                 strobe, fwValid, fwStore, allow, syncErr;
	logic [31:0]          fwWord, fwStoreWord;
	int                   errors = 0;
	int                   cmp_count = 0;
	always #2.5 clk_sys = ~clk_sys;
	isp_input_sync_param i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .odReq(odReq),
		.odRsp_q(odRsp_q), .firstSyncPulse(evt[0]), .secondSyncPulse(evt[1]),
		.inputBufferEvent(evt[2]), .outputBufferEvent(evt[3]), .sampleDone(evt[4]),
		.sampleStrobe_q(strobe), .stateA(stateA), .firmwareLoaderState(loader),
		.fwWordValid(fwValid), .fwWord(fwWord), .fwStoreValid_q(fwStore),
		.fwStoreWord_q(fwStoreWord), .calibWriteAllow_q(allow), .syncError_q(syncErr));
	isp_master_model i_master (.clk_sys(clk_sys), .odRsp_q(odRsp_q), .odReq(odReq),
		.fwWordValid(fwValid), .fwWord(fwWord));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic od(input logic w, input logic [15:0] idx, input logic [7:0] subIdx,
			input logic [31:0] d, input logic refuse, output logic [31:0] v);
		isp_pkg::isp_rsp_type rsp;
		i_master.access(w, idx, subIdx, d, rsp);
		chk("answer", {30'h0, 1'b1, refuse}, {30'h0, rsp.valid, rsp.abort});
		v = rsp.data;
	endtask
	task automatic fire(input int e);
		@(negedge clk_sys);
		evt[e] = 1'b1;
		@(negedge clk_sys);
		evt = 5'h0;
	endtask
	// Absolute timer offsets are a design choice, so only differences are judged.
	task automatic meas(input int a, input int b, input int gap, input int cp,
			output logic [31:0] t[3]);
		fire(a);
		repeat (gap) @(negedge clk_sys);
		fire(b);
		repeat (cp) @(negedge clk_sys);
		fire(4);
		od(1'b1, 16'h1c33, 8'h08, 32'h0, 1'b0, t[0]);
		od(1'b0, 16'h1c33, 8'h03, 32'h0, 1'b0, t[0]);
		od(1'b0, 16'h1c33, 8'h06, 32'h0, 1'b0, t[1]);
		od(1'b0, 16'h1c33, 8'h09, 32'h0, 1'b0, t[2]);
	endtask
	function automatic logic strobeExp(input logic [15:0] m, input int e);
		return (m == 16'h1 && e == 2) || (m == 16'h2 && e == 0)
			|| (m == 16'h3 && e == 1) || (m == 16'h22 && e == 3);
	endfunction
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk_sys);
		errors++;
		final_report();
	end
	initial begin
		logic [31:0] v, w, s[3], t[3];
		logic [7:0]  subs[13];
		logic [31:0] vals[13];
		logic [15:0] m;
		int          e, n;
		subs = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0b,
			8'h0c, 8'h0d, 8'h20};
		vals = '{32'h20, 32'h0, 32'hf4240, 32'h0, {17'h0, 1'b1, 8'h0, 6'h17}, 32'h186a0,
			32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
		e = $urandom(32'h3ca5);
		repeat (12) @(negedge clk_sys);
		rst_b = 1'b1;
		for (int i = 0; i < 13; i++) begin
			od(1'b0, 16'h1c33, subs[i], 32'h0, 1'b0, v);
			chk("reset value", vals[i], v);
		end
		$display("test reset values finished");
		od(1'b1, 16'h1c33, 8'h04, 32'h0, 1'b1, v);
		od(1'b1, 16'h1c33, 8'h01, 32'h5, 1'b1, v);
		od(1'b1, 16'h1c33, 8'h01, 32'h1_0002, 1'b1, v);
		od(1'b1, 16'h1c33, 8'h01, 32'h1_0001, 1'b1, v);
		w = $urandom;
		od(1'b1, 16'hf008, 8'h00, w, 1'b0, v);
		od(1'b0, 16'hf008, 8'h00, 32'h0, 1'b0, v);
		chk("code word", w, v);
		od(1'b1, 16'hf009, 8'h00, w | 32'h1, 1'b0, v);
		repeat (2) @(negedge clk_sys);
		chk("calibration unlock", 32'h0, allow);
		od(1'b1, 16'hf009, 8'h00, 32'h0, 1'b0, v);
		repeat (2) @(negedge clk_sys);
		chk("calibration unlock", 32'h1, allow);
		$display("test access kinds finished");
		for (int i = 0; i < 40; i++) begin
			m = (i % 5 == 4) ? 16'h22 : 16'(i % 5);
			od(1'b1, 16'h1c33, 8'h01, {16'h0, m}, 1'b0, v);
			e = $urandom_range(3);
			fire(e);
			chk("sample strobe", 32'(strobeExp(m, e)), 32'(strobe));
		end
		$display("test sync modes finished");
		od(1'b1, 16'h1c33, 8'h01, 32'h3, 1'b0, v);
		meas(0, 1, 10, 4, s);
		meas(0, 1, 30, 12, t);
		chk("shift growth", 32'h64, t[0] - s[0]);
		chk("copy growth", 32'h28, t[1] - s[1]);
		od(1'b1, 16'h1c33, 8'h01, 32'h2, 1'b0, v);
		meas(1, 0, 10, 4, s);
		meas(1, 0, 30, 4, t);
		chk("delay growth", 32'h64, t[2] - s[2]);
		$display("test timing finished");
		stateA = 1'b1;
		fire(2);
		fire(0);
		fire(4);
		od(1'b0, 16'h1c33, 8'h0b, 32'h0, 1'b0, v);
		fire(2);
		fire(2);
		od(1'b0, 16'h1c33, 8'h0b, 32'h0, 1'b0, w);
		chk("missed events", 32'h1, w - v);
		fire(0);
		fire(4);
		fire(0);
		@(negedge clk_sys);
		chk("sync error", 32'h0, syncErr);
		fire(0);
		@(negedge clk_sys);
		chk("sync error", 32'h1, syncErr);
		od(1'b1, 16'h1c33, 8'h01, 32'h22, 1'b0, v);
		fire(3);
		od(1'b0, 16'h1c33, 8'h0c, 32'h0, 1'b0, v);
		repeat (3) fire(3);
		od(1'b0, 16'h1c33, 8'h0c, 32'h0, 1'b0, w);
		chk("overruns", 32'h3, w - v);
		stateA = 1'b0;
		$display("test error tracking finished");
		loader = 1'b1;
		w = $urandom;
		i_master.load_fw(w, 8'h3c);
		chk("store pulse", 32'h1, fwStore);
		chk("stored word", w, fwStoreWord);
		loader = 1'b0;
		i_master.load_fw(~w, 8'h3c);
		chk("store pulse", 32'h0, fwStore);
		$display("test firmware finished");
		od(1'b1, 16'h1c33, 8'h02, 32'h32, 1'b0, v);
		od(1'b1, 16'h1c33, 8'h01, 32'h0, 1'b0, v);
		n = 0;
		repeat (40) begin
			@(negedge clk_sys);
			n += int'(strobe);
		end
		chk("free ticks", 32'h4, 32'(n));
		$display("test free run finished");
		final_report();
	end
endmodule
`default_nettype wire
